// >>> rtl/psp_pkg.sv
// constants for the parallel slave port block: map, fields, resets
package psp_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_PORT_D_DATA = 8'h08;
  localparam logic [7:0] IDX_PORT_E_DATA = 8'h09;
  localparam logic [7:0] IDX_IRQ_CONTROL = 8'h0a;
  localparam logic [7:0] IDX_PERIPH_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_PORT_D_DIRECTION = 8'h88;
  localparam logic [7:0] IDX_PORT_E_CTRL_STATUS = 8'h89;
  localparam logic [7:0] IDX_PERIPH_IRQ_ENABLES = 8'h8c;

  // bus widths and encodings
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PORT_W = 8;
  localparam int PORT_E_W = 3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // port_e_ctrl_status field positions
  localparam int BIT_INPUT_FULL = 7;
  localparam int BIT_OUTPUT_FULL = 6;
  localparam int BIT_INPUT_OVERFLOW = 5;
  localparam int BIT_MODE_ENABLE = 4;
  // irq flag, enable and global enable all sit at bit 7
  localparam int BIT_SLAVE_PORT_IRQ = 7;
  localparam int BIT_GLOBAL_IRQ = 7;

  // strobe and select positions on port E
  localparam int PE_READ_STROBE = 0;
  localparam int PE_WRITE_STROBE = 1;
  localparam int PE_SELECT = 2;

  // reset values
  localparam logic [7:0] RST_PORT_D_DIRECTION = 8'hff;
  localparam logic [2:0] RST_PORT_E_DIRECTION = 3'h7;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
endpackage

// >>> rtl/psp_top.sv
// parallel slave port with port D/E pins, behind an AHB-Lite register slave
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none

module psp_top
  import psp_pkg::*;
(
  input wire logic hclk, // bus clock, 100 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [ADDR_W-1:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [DATA_W-1:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic hreadyout, // slave ready out
  output logic [DATA_W-1:0] hrdata, // read data
  output logic hresp, // response, always okay
  input wire logic [PORT_W-1:0] pd_in, // port D pin levels
  output logic [PORT_W-1:0] pd_out, // port D drive value
  output logic [PORT_W-1:0] pd_oe, // port D drive enables
  input wire logic [PORT_E_W-1:0] pe_in, // port E pin levels
  output logic [PORT_E_W-1:0] pe_out, // port E drive value
  output logic [PORT_E_W-1:0] pe_oe, // port E drive enables
  output logic irq // level interrupt, active high
);

  // whole block state in one packed record
  typedef struct packed {
    logic [PORT_W-1:0] dir_d; // port_d_direction
    logic [PORT_E_W-1:0] dir_e; // port E direction bits
    logic mode; // slave_port_mode_enable
    logic input_full_flag; // input_full_flag
    logic output_full_flag; // output_full_flag
    logic input_overflow_flag; // input_overflow_flag
    logic [PORT_W-1:0] lat_out; // CPU-written output latch
    logic [PORT_W-1:0] lat_in; // host-written input latch
    logic [PORT_E_W-1:0] lat_e; // port E output latch
    logic [PORT_W-1:0] wdat; // data seen during host write strobe
    logic wr_act; // host write strobe active last cycle
    logic rd_act; // host read strobe active last cycle
    logic irq_flag; // slave_port_irq_flag
    logic irq_en; // slave_port_irq_enable
    logic global_irq_enable; // global_irq_enable
    logic pend; // bus data phase pending
    logic pwrite; // pending access is a write
    logic pok; // pending access is a valid word access
    logic [7:0] pidx; // pending register index
    logic hready; // hreadyout flop
    logic [DATA_W-1:0] hrdata; // hrdata flop
    logic hresp; // hresp flop
    logic [PORT_W-1:0] pd_out; // port D output flop
    logic [PORT_W-1:0] pd_oe; // port D enable flop
    logic [PORT_E_W-1:0] pe_out; // port E output flop
    logic [PORT_E_W-1:0] pe_oe; // port E enable flop
    logic irq; // interrupt output flop
  } psp_state_type;

  psp_state_type st_r; // registered state
  psp_state_type st_nxt; // next state

  // host-side events, decoded straight from the unregistered port E pins
  logic sel_now; // select asserted (low)
  logic wr_now; // selected write strobe low
  logic rd_now; // selected read strobe low
  logic wr_done; // host write finished this cycle
  logic rd_done; // host read finished this cycle
  // CPU-side events at the access edge
  logic cpu_acc; // register access performed now
  logic cpu_rd_pd; // CPU reads port_d_data
  logic cpu_wr_pd; // CPU writes port_d_data
  logic irq_cond; // flag and both enables set, checker helper

  // register read mux, used for the bus answer
  function automatic logic [7:0] reg_read(
    input psp_state_type s,
    input logic [7:0] idx,
    input logic [PORT_W-1:0] pins_d,
    input logic [PORT_E_W-1:0] pins_e
  );
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      IDX_PORT_D_DATA: begin
        // slave mode reads the input latch, else the pins
        v = s.mode ? s.lat_in : pins_d;
      end
      IDX_PORT_E_DATA: begin
        v = {5'h00, pins_e};
      end
      IDX_IRQ_CONTROL: begin
        v[BIT_GLOBAL_IRQ] = s.global_irq_enable;
      end
      IDX_PERIPH_IRQ_FLAGS: begin
        v[BIT_SLAVE_PORT_IRQ] = s.irq_flag;
      end
      IDX_PORT_D_DIRECTION: begin
        v = s.dir_d;
      end
      IDX_PORT_E_CTRL_STATUS: begin
        v = {s.input_full_flag, s.output_full_flag, s.input_overflow_flag, s.mode, 1'b0, s.dir_e};
      end
      IDX_PERIPH_IRQ_ENABLES: begin
        v[BIT_SLAVE_PORT_IRQ] = s.irq_en;
      end
      default: begin
        // unmapped index reads as zero
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  // host strobe decode; pins are low-active and only count in slave mode
  assign sel_now = st_r.mode & ~pe_in[PE_SELECT];
  assign wr_now = sel_now & ~pe_in[PE_WRITE_STROBE];
  assign rd_now = sel_now & ~pe_in[PE_READ_STROBE];
  // an access completes when its strobe or the select goes away
  assign wr_done = st_r.wr_act & ~wr_now;
  assign rd_done = st_r.rd_act & ~rd_now;

  // CPU access happens in the single wait cycle of the data phase
  assign cpu_acc = st_r.pend & st_r.pok;
  assign cpu_rd_pd = cpu_acc & ~st_r.pwrite & (st_r.pidx == IDX_PORT_D_DATA);
  assign cpu_wr_pd = cpu_acc & st_r.pwrite & (st_r.pidx == IDX_PORT_D_DATA);
  // any of the three may drop, so the checker watches all of them together
  assign irq_cond = st_r.irq_flag & st_r.irq_en & st_r.global_irq_enable;

  // next-state logic for the whole block
  always_comb begin
    logic [7:0] wb;
    wb = hwdata[7:0];
    st_nxt = st_r;

    // bus: take address phase, answer after one wait cycle
    if (st_r.pend) begin
      st_nxt.pend = 1'b0;
      st_nxt.hready = 1'b1;
      st_nxt.hrdata = RST_RDATA;
      if (st_r.pok && !st_r.pwrite) begin
        st_nxt.hrdata = {24'h00_0000, reg_read(st_r, st_r.pidx, pd_in, pe_in)};
      end
    end else if (hsel && htrans[1] && hready) begin
      // wrong sizes are accepted with okay and have no effect
      st_nxt.pend = 1'b1;
      st_nxt.pwrite = hwrite;
      st_nxt.pok = (hsize == HSIZE_WORD) && (haddr[1:0] == 2'b00);
      st_nxt.pidx = haddr[9:2];
      st_nxt.hready = 1'b0;
    end
    st_nxt.hresp = HRESP_OKAY;

    // register writes; hwdata is stable in the wait cycle
    if (cpu_acc && st_r.pwrite) begin
      unique case (st_r.pidx)
        IDX_PORT_D_DATA: begin
          st_nxt.lat_out = wb;
        end
        IDX_PORT_E_DATA: begin
          st_nxt.lat_e = wb[PORT_E_W-1:0];
        end
        IDX_IRQ_CONTROL: begin
          st_nxt.global_irq_enable = wb[BIT_GLOBAL_IRQ];
        end
        IDX_PERIPH_IRQ_FLAGS: begin
          // write one to clear; a new event below still wins
          if (wb[BIT_SLAVE_PORT_IRQ]) begin
            st_nxt.irq_flag = 1'b0;
          end
        end
        IDX_PORT_D_DIRECTION: begin
          st_nxt.dir_d = wb;
        end
        IDX_PORT_E_CTRL_STATUS: begin
          // full flags are read only; overflow clears on a written zero
          st_nxt.mode = wb[BIT_MODE_ENABLE];
          st_nxt.dir_e = wb[PORT_E_W-1:0];
          if (!wb[BIT_INPUT_OVERFLOW]) begin
            st_nxt.input_overflow_flag = 1'b0;
          end
        end
        IDX_PERIPH_IRQ_ENABLES: begin
          st_nxt.irq_en = wb[BIT_SLAVE_PORT_IRQ];
        end
        default: begin
          // unmapped write is dropped
          st_nxt.global_irq_enable = st_r.global_irq_enable;
        end
      endcase
    end

    // CPU reading the input latch empties it
    if (cpu_rd_pd && st_r.mode) begin
      st_nxt.input_full_flag = 1'b0;
    end
    // CPU writing the output latch fills it for the host
    if (cpu_wr_pd && st_r.mode) begin
      st_nxt.output_full_flag = 1'b1;
    end

    // host strobe tracking; data follows the pins while the write is low
    st_nxt.wr_act = wr_now;
    st_nxt.rd_act = rd_now;
    if (wr_now) begin
      st_nxt.wdat = pd_in;
    end

    // host write completes: store or flag overflow, keeping the old word
    if (wr_done) begin
      if (st_r.input_full_flag && !cpu_rd_pd) begin
        st_nxt.input_overflow_flag = 1'b1;
      end else begin
        st_nxt.lat_in = st_r.wdat;
        st_nxt.input_full_flag = 1'b1;
      end
    end
    // host read completes: output latch is consumed; a CPU fill in the same cycle wins over the clear
    if (rd_done) begin
      st_nxt.output_full_flag = 1'b0;
      if (cpu_wr_pd) begin
        st_nxt.output_full_flag = 1'b1;
      end
    end

    // any finished host access latches the flag, whatever the enables
    if (wr_done || rd_done) begin
      st_nxt.irq_flag = 1'b1;
    end

    // outside slave mode the full flags stay clear; overflow is kept
    if (!st_nxt.mode) begin
      st_nxt.input_full_flag = 1'b0;
      st_nxt.output_full_flag = 1'b0;
    end

    // pin drive; slave mode ignores the direction register
    st_nxt.pd_out = st_r.lat_out;
    if (st_r.mode) begin
      st_nxt.pd_oe = rd_now ? {PORT_W{1'b1}} : {PORT_W{1'b0}};
      st_nxt.pe_oe = {PORT_E_W{1'b0}};
    end else begin
      st_nxt.pd_oe = ~st_r.dir_d;
      st_nxt.pe_oe = ~st_r.dir_e;
    end
    st_nxt.pe_out = st_r.lat_e;

    // interrupt only while both enables allow it
    st_nxt.irq = st_r.irq_flag & st_r.irq_en & st_r.global_irq_enable;
  end

  // state register; reset takes constants only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.dir_d <= RST_PORT_D_DIRECTION;
      st_r.dir_e <= RST_PORT_E_DIRECTION;
      st_r.lat_out <= RST_LATCH;
      st_r.lat_in <= RST_LATCH;
      st_r.hready <= 1'b1;
      st_r.hrdata <= RST_RDATA;
      st_r.pd_oe <= '0;
      st_r.pe_oe <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign hreadyout = st_r.hready;
  assign hrdata = st_r.hrdata;
  assign hresp = st_r.hresp;
  assign pd_out = st_r.pd_out;
  assign pd_oe = st_r.pd_oe;
  assign pe_out = st_r.pe_out;
  assign pe_oe = st_r.pe_oe;
  assign irq = st_r.irq;

  // checks on the block's own outputs and flags
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_read_drive;
    rd_now |=> (pd_oe == {PORT_W{1'b1}}) && (pd_out == $past(st_r.lat_out));
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("pins not driven on host read");

  property p_slave_float;
    (st_r.mode && !rd_now) |=> (pd_oe == {PORT_W{1'b0}}) && (pe_oe == {PORT_E_W{1'b0}});
  endproperty
  a_slave_float: assert property (p_slave_float) else $error("pins driven while idle");

  property p_gpio_dir;
    !st_r.mode |=> pd_oe == ~$past(st_r.dir_d);
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("port D enable not from direction");

  property p_write_store;
    (wr_done && !st_r.input_full_flag && st_r.mode) |=> st_r.input_full_flag && (st_r.lat_in == $past(st_r.wdat));
  endproperty
  a_write_store: assert property (p_write_store) else $error("host word not stored");

  property p_overflow;
    (wr_done && st_r.input_full_flag && !cpu_rd_pd) |=> st_r.input_overflow_flag && $stable(st_r.lat_in);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_out_full;
    (cpu_wr_pd && st_r.mode && st_nxt.mode) |=> st_r.output_full_flag [*1] ##1 (st_r.output_full_flag || $past(rd_done));
  endproperty
  a_out_full: assert property (p_out_full) else $error("output full not set");

  property p_flags_off;
    !st_r.mode |-> !st_r.input_full_flag && !st_r.output_full_flag;
  endproperty
  a_flags_off: assert property (p_flags_off) else $error("full flags set outside mode");

  property p_irq_flag;
    (wr_done || rd_done) |=> st_r.irq_flag;
  endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("access did not set flag");

  property p_irq_gate;
    irq_cond |=> irq ##1 (irq || !$past(irq_cond));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not raised");

  property p_irq_masked;
    !st_r.irq_en |=> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt seen");

  property p_flag_masked;
    ((wr_done || rd_done) && !(st_r.irq_en && st_r.global_irq_enable)) |=> st_r.irq_flag;
  endproperty
  a_flag_masked: assert property (p_flag_masked) else $error("masked event lost flag");

  property p_bus_answer;
    (hsel && htrans[1] && hready && hreadyout) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

endmodule

`default_nettype wire

// >>> tb/psp_host_model.sv
// behavioural external host driving the slave port strobes and data lines
`timescale 1ns/1ps
`default_nettype none
module psp_host_model
  import psp_pkg::*;
(
  input wire logic hclk, // clock the strobes are stepped on
  input wire logic [PORT_W-1:0] pd_out, // device drive value
  input wire logic [PORT_W-1:0] pd_oe, // device drive enables
  output logic [PORT_W-1:0] pd_in, // resolved data line levels
  output logic [PORT_E_W-1:0] pe_in // read, write, select strobes, low active
);
  logic [PORT_W-1:0] host_d = 8'h00; // value the host puts on the lines
  logic host_oe = 1'b0; // host drives the lines
  logic [PORT_W-1:0] last_d = 8'h00; // last resolved level

  // strobes idle high between accesses
  initial pe_in = 3'h7;

  // a released line shows the inverse of its last level, so stale data never matches
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (pd_oe[i]) begin
        pd_in[i] = pd_out[i];
      end else if (host_oe) begin
        pd_in[i] = host_d[i];
      end else begin
        pd_in[i] = ~last_d[i];
      end
    end
  end

  // remember the line level for the released case
  always_ff @(posedge hclk) begin
    last_d <= pd_in;
  end

  // write: select and write strobe low with data, then strobes high
  task automatic wr(input logic [7:0] d, input int hold);
    @(posedge hclk);
    pe_in <= 3'h1;
    host_d <= d;
    host_oe <= 1'b1;
    repeat (hold) @(posedge hclk);
    pe_in <= 3'h7;
    host_oe <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask

  // read: hold at least two cycles so the device has turned the lines round
  task automatic rd(output logic [7:0] q, input int hold);
    @(posedge hclk);
    pe_in <= 3'h2;
    repeat (hold) @(posedge hclk);
    q = pd_in;
    pe_in <= 3'h7;
    repeat (2) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// >>> tb/psp_top_test.sv
// self-checking bench for the parallel slave port block
`timescale 1ns/1ps
`default_nettype none
module psp_top_test;
  import psp_pkg::*;
  logic hclk = 1'b0; // bus clock
  logic hresetn = 1'b0; // reset, active low
  logic hsel = 1'b1; // the only slave, always selected
  logic [ADDR_W-1:0] haddr = 12'h000; // byte address
  logic [1:0] htrans = 2'h0; // transfer type
  logic hwrite = 1'b0; // write when high
  logic [2:0] hsize = 3'h2; // word size
  logic [DATA_W-1:0] hwdata = 32'h0000_0000; // write data
  logic hreadyout; // slave ready, also the bus ready
  logic [DATA_W-1:0] hrdata; // read data
  logic hresp; // bus response
  logic [PORT_W-1:0] pd_in, pd_out, pd_oe; // port D lines
  logic [PORT_E_W-1:0] pe_in, pe_out, pe_oe; // port E lines
  logic irq; // level interrupt
  logic [31:0] exp_q[$]; // expected results, oldest first
  logic [31:0] got_q[$]; // observed results
  int miscompares = 0; // mismatch count
  int total_checks = 0; // comparison count

  psp_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe), .pe_in(pe_in),
    .pe_out(pe_out), .pe_oe(pe_oe), .irq(irq));
  psp_host_model i_host (.hclk(hclk), .pd_out(pd_out), .pd_oe(pd_oe),
    .pd_in(pd_in), .pe_in(pe_in));

  // free running clock
  initial begin
    forever #5 hclk = ~hclk;
  end

  // one AHB single transfer; waits on ready, no fixed latency assumed
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    haddr <= {2'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] q;
    exp_q.push_back({24'h00_0000, e});
    bus(1'b0, idx, 32'h0000_0000, q);
    got_q.push_back(q);
    // response must be okay on every read answer
    now(8'h00, {7'h00, hresp});
  endtask

  // a pin level checked where it stands right now
  task automatic now(input logic [7:0] e, input logic [7:0] v);
    exp_q.push_back({24'h00_0000, e});
    got_q.push_back({24'h00_0000, v});
  endtask

  task automatic hrd(input logic [7:0] e, input int hold);
    logic [7:0] q;
    exp_q.push_back({24'h00_0000, e});
    i_host.rd(q, hold);
    got_q.push_back({24'h00_0000, q});
  endtask

  task automatic end_test(input string name);
    $display("test %s done at %0t", name, $time);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watcher: pairs each observed result with the oldest expectation
  initial begin
    forever begin
      wait (got_q.size() != 0);
      total_checks++;
      if (got_q[0] !== exp_q[0]) begin
        miscompares++;
        $display("[FAIL] %0t got %h expected %h", $time, got_q[0], exp_q[0]);
      end
      got_q.delete(0);
      exp_q.delete(0);
    end
  end

  // watchdog well beyond the expected run
  initial begin
    #200000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] e;
    void'($urandom(32'hf613_407e));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(IDX_PORT_D_DIRECTION, 8'hff);
    rdchk(IDX_PORT_E_CTRL_STATUS, 8'h07);
    rdchk(IDX_PERIPH_IRQ_FLAGS, 8'h00);
    rdchk(IDX_PERIPH_IRQ_ENABLES, 8'h00);
    wr(8'h40, 32'hffff_ffff);
    rdchk(8'h40, 8'h00);
    end_test("reset");
    // general i/o: direction drives enables, strobes have no effect
    wr(IDX_PORT_D_DIRECTION, 32'h0000_000f);
    repeat (2) @(posedge hclk);
    now(8'hf0, pd_oe);
    i_host.wr(8'h5a, 2);
    rdchk(IDX_PORT_E_CTRL_STATUS, 8'h07);
    rdchk(IDX_PERIPH_IRQ_FLAGS, 8'h00);
    // port E as general i/o: latch drives pins, direction gives enables
    wr(IDX_PORT_E_DATA, 32'h0000_0005);
    wr(IDX_PORT_E_CTRL_STATUS, 32'h0000_0002);
    repeat (2) @(posedge hclk);
    now(8'h05, {5'h00, pe_out});
    now(8'h05, {5'h00, pe_oe});
    rdchk(IDX_PORT_E_DATA, 8'h07);
    end_test("io mode");
    // slave mode on; read-only flags must not take the written ones
    wr(IDX_PORT_E_CTRL_STATUS, 32'hffff_ffd7);
    rdchk(IDX_PORT_E_CTRL_STATUS, 8'h17);
    repeat (2) @(posedge hclk);
    now(8'h00, pd_oe);
    now(8'h00, {5'h00, pe_oe});
    d = 8'($urandom);
    e = 8'($urandom);
    i_host.wr(d, 1);
    rdchk(IDX_PORT_E_CTRL_STATUS, 8'h97);
    rdchk(IDX_PERIPH_IRQ_FLAGS, 8'h80);
    now(8'h00, {7'h00, irq});
    i_host.wr(e, 3);
    rdchk(IDX_PORT_E_CTRL_STATUS, 8'hb7);
    rdchk(IDX_PORT_D_DATA, d);
    rdchk(IDX_PORT_E_CTRL_STATUS, 8'h37);
    end_test("host write");
    // cpu to host, overflow still standing
    wr(IDX_PORT_D_DATA, {24'h00_0000, e});
    rdchk(IDX_PORT_E_CTRL_STATUS, 8'h77);
    wr(IDX_PERIPH_IRQ_FLAGS, 32'h0000_0080);
    hrd(e, 3);
    rdchk(IDX_PORT_E_CTRL_STATUS, 8'h37);
    rdchk(IDX_PERIPH_IRQ_FLAGS, 8'h80);
    end_test("host read");
    // interrupt raised, masked, cleared
    wr(IDX_PERIPH_IRQ_ENABLES, 32'h0000_0080);
    wr(IDX_IRQ_CONTROL, 32'h0000_0080);
    repeat (2) @(posedge hclk);
    now(8'h01, {7'h00, irq});
    wr(IDX_PERIPH_IRQ_ENABLES, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    now(8'h00, {7'h00, irq});
    wr(IDX_PERIPH_IRQ_ENABLES, 32'h0000_0080);
    wr(IDX_PERIPH_IRQ_FLAGS, 32'h0000_0080);
    repeat (2) @(posedge hclk);
    now(8'h00, {7'h00, irq});
    rdchk(IDX_PERIPH_IRQ_FLAGS, 8'h00);
    end_test("interrupt");
    // random round trips, prompt and slow host
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      i_host.wr(d, 1 + int'($urandom % 3));
      rdchk(IDX_PORT_D_DATA, d);
      wr(IDX_PORT_D_DATA, {24'h00_0000, ~d});
      hrd(~d, 2 + int'($urandom % 3));
    end
    rdchk(IDX_PORT_E_CTRL_STATUS, 8'h37);
    end_test("random");
    // leaving slave mode with output full and overflow set
    wr(IDX_PORT_D_DATA, 32'h0000_003c);
    wr(IDX_PORT_E_CTRL_STATUS, 32'h0000_0027);
    rdchk(IDX_PORT_E_CTRL_STATUS, 8'h27);
    wr(IDX_PORT_E_CTRL_STATUS, 32'h0000_0007);
    rdchk(IDX_PORT_E_CTRL_STATUS, 8'h07);
    end_test("mode off");
    repeat (2) @(posedge hclk);
    stop_test();
  end
endmodule
`default_nettype wire
